// >>> lrc_pkg.sv
// Behaviour
// - host byte is taken on the rising edge of chip select
// - data bytes after the write command go to SRAM at write counter
// - forty bytes fill one 320-dot line; next byte starts the next line
// - auto mode: a display write during a frame makes the next frame active
// - auto mode: a frame without display writes or a transfer command is followed by a doze frame
// - active frame: read SRAM and run the shift clock to the drivers
// - doze frame: no refresh reads, shift clock held off
// - manual mode: transfer command makes the next frame active
// - manual mode: after one sent frame, doze until the next transfer command
// - a transfer command right after another transfer command is ignored
// - sleep input low shuts the display down, SRAM contents kept
// - sleep: SRAM address low, selects high, SRAM data bus floated
// - sleep: LCD outputs and blank low, SRAM output enable and strobe high
// - sleep: host data, clock, select and type inputs ignored; reset input still acts
// - shift burst starts four bus cycles after the line pulse
// - frame polarity toggles once per frame
// - each bus cycle: refresh read in low phase, host write in high phase
// - reset size is 320 dots by 200 lines, width in bytes
// - command 02h selects auto mode, 03h selects manual mode
// - command 04h forces the next frame active in either mode
package lrc_pkg;
    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_SIZE   = 8'h01;
    localparam logic [7:0] CMD_AUTO   = 8'h02;
    localparam logic [7:0] CMD_MANUAL = 8'h03;
    localparam logic [7:0] CMD_XFER   = 8'h04;
    localparam logic [7:0] CMD_WRITE  = 8'h05;
    localparam logic [7:0] CMD_WADDR  = 8'h06;
    localparam logic [7:0] CMD_RADDR  = 8'h07;
    localparam logic [6:0] CMD_ONOFF  = 7'h40;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [5:0] HSIZE_RST  = 6'h27;
    localparam logic [7:0] VSIZE_RST  = 8'hC7;
    localparam logic       AUTO_RST   = 1'b1;
    localparam logic       BLANK_RST  = 1'b0;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int MCLK_MHZ        = 50;
    localparam int LP_HIGH_NS      = 700;
    localparam int LP_HIGH_CYC     = (LP_HIGH_NS * MCLK_MHZ + 999) / 1000;
    localparam int BUS_CYC_MCLK    = 2;
    localparam int SHIFT_DELAY_BUS = 4;
    localparam int SHIFT_DELAY_CYC = SHIFT_DELAY_BUS * BUS_CYC_MCLK;

    typedef enum logic [1:0] {
        LRC_IDLE  = 2'b00,
        LRC_WAIT  = 2'b01,
        LRC_SHIFT = 2'b11
    } lrc_line_e;
endpackage

// >>> lrc_sram_model.sv
`timescale 1ns/1ps
// ----
// byte-wide sram, two banks
// ----
module lrc_sram_model (
    input  wire logic        i_clk,
    input  wire logic [14:0] i_addr,
    input  wire logic [1:0]  i_sel_n,
    input  wire logic [7:0]  i_data,
    input  wire logic        i_data_oe,
    input  wire logic        i_oe_n,
    input  wire logic        i_we_n,
    output logic      [7:0]  o_data
);
    logic [7:0] mem [0:65535];
    logic       hit;
    initial begin
        for (int k = 0; k < 65536; k++) begin
            mem[k] = 8'h00;
        end
    end
    assign hit = (i_sel_n != 2'b11);
    // bank bit is the select that went low
    always_ff @(posedge i_clk) begin
        if (!i_we_n && i_data_oe && hit) begin
            mem[{i_sel_n[0], i_addr}] <= i_data;
        end
    end
    // a released bus shows the pull-up level, never the last byte
    assign o_data = (!i_oe_n && hit) ? mem[{i_sel_n[0], i_addr}] : 8'hFF;
endmodule

// >>> lrc_top.sv
`timescale 1ns/1ps
module lrc_top (
    input  wire logic        I_MCLK,
    input  wire logic        I_SRST,
    input  wire logic        I_BUS_CLK,
    input  wire logic        I_CS_N,
    input  wire logic [7:0]  I_DATA,
    input  wire logic        I_DATA_OR_COMMAND,
    input  wire logic        I_SLEEP_N,
    input  wire logic        I_OSCILLATOR_INPUT,
    input  wire logic [7:0]  I_SRAM_DATA,
    output logic      [14:0] O_SRAM_ADDR,
    output logic      [1:0]  O_SRAM_SELECT_N,
    output logic      [7:0]  O_SRAM_DATA,
    output logic             O_SRAM_DATA_OE,
    output logic             O_SRAM_OUTPUT_ENABLE_N,
    output logic             O_SRAM_WRITE_STROBE_N,
    output logic      [7:0]  O_LCD_PIXEL_BUS,
    output logic             O_SEGMENT_SHIFT_CLOCK_GATED,
    output logic             O_LINE_LATCH_PULSE,
    output logic             O_FRAME_START_PULSE,
    output logic             O_FRAME_POLARITY,
    output logic             O_DISPLAY_BLANK_N,
    output logic             O_ACTIVE_FRAME,
    output logic             O_AUTO_MODE
);
    // ------------------------------------------------------------
    // link domain: host strobe capture
    // ------------------------------------------------------------
    typedef struct packed {
        logic       rst_s1;
        logic       rst_s2;
        logic       cs_s1;
        logic       cs_s2;
        logic       cs_s3;
        logic [7:0] dat_s1;
        logic [7:0] dat_s2;
        logic       dc_s1;
        logic       dc_s2;
        logic [7:0] byte_v;
        logic       dc;
        logic       tog;
    } lrc_link_s;
    lrc_link_s k_q;
    lrc_link_s k_d;
    always_comb begin
        k_d        = k_q;
        k_d.rst_s1 = I_SRST;
        k_d.rst_s2 = k_q.rst_s1;
        k_d.cs_s1  = I_CS_N;
        k_d.cs_s2  = k_q.cs_s1;
        k_d.cs_s3  = k_q.cs_s2;
        k_d.dat_s1 = I_DATA;
        k_d.dat_s2 = k_q.dat_s1;
        k_d.dc_s1  = I_DATA_OR_COMMAND;
        k_d.dc_s2  = k_q.dc_s1;
        // byte held still until the next edge, so the toggle carries it
        if (k_q.cs_s2 && !k_q.cs_s3) begin
            k_d.byte_v = k_q.dat_s2;
            k_d.dc     = k_q.dc_s2;
            k_d.tog    = !k_q.tog;
        end
        if (k_q.rst_s2) begin
            k_d.tog    = 1'b0;
            k_d.byte_v = 8'h00;
            k_d.dc     = 1'b0;
        end
    end
    always_ff @(posedge I_BUS_CLK) begin
        k_q <= k_d;
    end

    // ------------------------------------------------------------
    // main domain state
    // ------------------------------------------------------------
    typedef struct packed {
        logic                tog_s1;
        logic                tog_s2;
        logic                tog_s3;
        logic                slp_s1;
        logic                slp_s2;
        logic                osc_s1;
        logic                osc_s2;
        logic                osc_s3;
        logic [7:0]          sd_s1;
        logic [7:0]          sd_s2;
        logic                phase;
        logic [7:0]          cmd;
        logic [1:0]          didx;
        logic                prev_xfer;
        logic                auto_mode;
        logic [15:0]         wr_addr;
        logic [15:0]         rf_start;
        logic [15:0]         rf_addr;
        logic [5:0]          hsize;
        logic [7:0]          vsize;
        logic                blank_n;
        logic                written;
        logic                force_act;
        logic                active;
        logic [7:0]          line;
        lrc_pkg::lrc_line_e  lstate;
        logic [5:0]          dly;
        logic [5:0]          lp_cnt;
        logic [5:0]          bytes;
        logic [3:0]          rd_pipe;
        logic                wr_pend;
        logic [7:0]          wr_data;
        logic [14:0]         addr;
        logic [1:0]          sel_n;
        logic [7:0]          dout;
        logic                doe;
        logic                oe_n;
        logic                we_n;
        logic [7:0]          pix;
        logic                sclk;
        logic                lp;
        logic                yd;
        logic                fr;
        logic                dispn;
    } lrc_main_s;
    lrc_main_s r_q;
    lrc_main_s r_d;
    logic      awake;
    logic      host_ev;
    logic      osc_ev;
    logic      new_act;
    logic [15:0] acc;
    always_comb begin
        r_d        = r_q;
        r_d.tog_s1 = k_q.tog;
        r_d.tog_s2 = r_q.tog_s1;
        r_d.tog_s3 = r_q.tog_s2;
        r_d.slp_s1 = I_SLEEP_N;
        r_d.slp_s2 = r_q.slp_s1;
        r_d.osc_s1 = I_OSCILLATOR_INPUT;
        r_d.osc_s2 = r_q.osc_s1;
        r_d.osc_s3 = r_q.osc_s2;
        r_d.sd_s1  = I_SRAM_DATA;
        r_d.sd_s2  = r_q.sd_s1;
        awake      = r_q.slp_s2;
        host_ev    = (r_q.tog_s2 ^ r_q.tog_s3) && awake;
        osc_ev     = r_q.osc_s2 && !r_q.osc_s3 && awake;
        new_act    = 1'b0;
        acc        = 16'h0000;
        r_d.phase  = !r_q.phase;
        r_d.rd_pipe = {r_q.rd_pipe[2:0], 1'b0};
        // ---------------- sram bus, one phase per mclk ----------------
        r_d.oe_n   = 1'b1;
        r_d.we_n   = 1'b1;
        r_d.doe    = 1'b0;
        if (!r_q.phase) begin
            if (r_q.lstate == lrc_pkg::LRC_SHIFT && r_q.active) begin
                acc          = r_q.rf_addr;
                r_d.oe_n     = 1'b0;
                r_d.rf_addr  = r_q.rf_addr + 16'h0001;
                r_d.bytes    = r_q.bytes + 6'h01;
                r_d.rd_pipe[0] = 1'b1;
                if (r_q.bytes == r_q.hsize) begin
                    r_d.lstate = lrc_pkg::LRC_IDLE;
                end
            end
        end else if (r_q.wr_pend && awake) begin
            acc         = r_q.wr_addr;
            r_d.we_n    = 1'b0;
            r_d.doe     = 1'b1;
            r_d.dout    = r_q.wr_data;
            r_d.wr_addr = r_q.wr_addr + 16'h0001;
            r_d.wr_pend = 1'b0;
        end
        r_d.addr  = acc[14:0];
        r_d.sel_n = {!acc[15], acc[15]};
        // data shows one cycle before the shift clock rises
        if (r_q.rd_pipe[2]) begin
            r_d.pix = r_q.sd_s2;
        end
        r_d.sclk = r_q.rd_pipe[3] && r_q.active;
        // ---------------- line and frame timing ----------------
        if (r_q.lp_cnt != 6'h00) begin
            r_d.lp_cnt = r_q.lp_cnt - 6'h01;
        end else begin
            r_d.lp = 1'b0;
            r_d.yd = 1'b0;
        end
        if (r_q.lstate == lrc_pkg::LRC_WAIT) begin
            if (r_q.dly == 6'h01) begin
                r_d.lstate = r_q.active ? lrc_pkg::LRC_SHIFT
                                        : lrc_pkg::LRC_IDLE;
            end
            r_d.dly = r_q.dly - 6'h01;
        end
        if (osc_ev) begin
            r_d.lp     = 1'b1;
            r_d.lp_cnt = 6'(lrc_pkg::LP_HIGH_CYC - 1);
            r_d.dly    = 6'(lrc_pkg::SHIFT_DELAY_CYC);
            r_d.lstate = lrc_pkg::LRC_WAIT;
            r_d.bytes  = 6'h00;
            r_d.line   = r_q.line + 8'h01;
            if (r_q.line == r_q.vsize) begin
                r_d.line    = 8'h00;
                r_d.yd      = 1'b1;
                r_d.fr      = !r_q.fr;
                r_d.rf_addr = r_q.rf_start;
                // manual mode only wakes on the transfer request
                new_act = r_q.auto_mode ? (r_q.written || r_q.force_act)
                                        : r_q.force_act;
                r_d.active    = new_act;
                r_d.force_act = 1'b0;
                r_d.written   = 1'b0;
            end
        end
        // ---------------- host commands and data ----------------
        if (host_ev) begin
            if (!k_q.dc) begin
                r_d.cmd       = k_q.byte_v;
                r_d.didx      = 2'b00;
                r_d.prev_xfer = (k_q.byte_v == lrc_pkg::CMD_XFER);
                if (k_q.byte_v == lrc_pkg::CMD_AUTO) begin
                    r_d.auto_mode = 1'b1;
                end else if (k_q.byte_v == lrc_pkg::CMD_MANUAL) begin
                    r_d.auto_mode = 1'b0;
                end else if (k_q.byte_v == lrc_pkg::CMD_XFER) begin
                    if (!r_q.prev_xfer) begin
                        r_d.force_act = 1'b1;
                    end
                end else if (k_q.byte_v[7:1] == lrc_pkg::CMD_ONOFF) begin
                    r_d.blank_n = k_q.byte_v[0];
                end
            end else begin
                r_d.didx = (r_q.didx == 2'b11) ? 2'b11 : r_q.didx + 2'b01;
                case (r_q.cmd)
                    lrc_pkg::CMD_SIZE: begin
                        if (r_q.didx == 2'b00) begin
                            r_d.hsize = k_q.byte_v[5:0];
                        end else if (r_q.didx == 2'b01) begin
                            r_d.vsize = k_q.byte_v;
                        end
                    end
                    lrc_pkg::CMD_WADDR: begin
                        if (r_q.didx == 2'b00) begin
                            r_d.wr_addr[7:0] = k_q.byte_v;
                        end else if (r_q.didx == 2'b01) begin
                            r_d.wr_addr[15:8] = k_q.byte_v;
                        end
                    end
                    lrc_pkg::CMD_RADDR: begin
                        if (r_q.didx == 2'b00) begin
                            r_d.rf_start[7:0] = k_q.byte_v;
                        end else if (r_q.didx == 2'b01) begin
                            r_d.rf_start[15:8] = k_q.byte_v;
                        end
                    end
                    lrc_pkg::CMD_WRITE: begin
                        // new byte beats the clear done by the write slot
                        r_d.wr_pend = 1'b1;
                        r_d.wr_data = k_q.byte_v;
                        r_d.written = 1'b1;
                    end
                    default: r_d.didx = r_d.didx;
                endcase
            end
        end
        r_d.dispn = r_q.blank_n;
        // ---------------- sleep forcing ----------------
        if (!awake) begin
            r_d.lstate  = lrc_pkg::LRC_IDLE;
            r_d.rd_pipe = 4'b0000;
            r_d.addr    = 15'h0000;
            r_d.sel_n   = 2'b11;
            r_d.doe     = 1'b0;
            r_d.oe_n    = 1'b1;
            r_d.we_n    = 1'b1;
            r_d.fr      = 1'b0;
            r_d.yd      = 1'b0;
            r_d.lp      = 1'b0;
            r_d.sclk    = 1'b0;
            r_d.pix     = 8'h00;
            r_d.dispn   = 1'b0;
        end
        // ---------------- synchronous reset ----------------
        if (I_SRST) begin
            r_d.tog_s1 = 1'b0;
            r_d.tog_s2 = 1'b0;
            r_d.tog_s3 = 1'b0;
            r_d.phase  = 1'b0;
            r_d.cmd    = 8'h00;
            r_d.didx   = 2'b00;
            r_d.prev_xfer = 1'b0;
            r_d.auto_mode = lrc_pkg::AUTO_RST;
            r_d.wr_addr   = 16'h0000;
            r_d.rf_start  = 16'h0000;
            r_d.rf_addr   = 16'h0000;
            r_d.hsize     = lrc_pkg::HSIZE_RST;
            r_d.vsize     = lrc_pkg::VSIZE_RST;
            r_d.blank_n   = lrc_pkg::BLANK_RST;
            r_d.written   = 1'b0;
            r_d.force_act = 1'b0;
            r_d.active    = 1'b0;
            r_d.line      = 8'h00;
            r_d.lstate    = lrc_pkg::LRC_IDLE;
            r_d.dly       = 6'h00;
            r_d.lp_cnt    = 6'h00;
            r_d.bytes     = 6'h00;
            r_d.rd_pipe   = 4'b0000;
            r_d.wr_pend   = 1'b0;
            r_d.wr_data   = 8'h00;
            r_d.addr      = 15'h0000;
            r_d.sel_n     = 2'b11;
            r_d.dout      = 8'h00;
            r_d.doe       = 1'b0;
            r_d.oe_n      = 1'b1;
            r_d.we_n      = 1'b1;
            r_d.pix       = 8'h00;
            r_d.sclk      = 1'b0;
            r_d.lp        = 1'b0;
            r_d.yd        = 1'b0;
            r_d.fr        = 1'b0;
            r_d.dispn     = 1'b0;
        end
    end
    always_ff @(posedge I_MCLK) begin
        r_q <= r_d;
    end
    assign O_SRAM_ADDR                 = r_q.addr;
    assign O_SRAM_SELECT_N             = r_q.sel_n;
    assign O_SRAM_DATA                 = r_q.dout;
    assign O_SRAM_DATA_OE              = r_q.doe;
    assign O_SRAM_OUTPUT_ENABLE_N      = r_q.oe_n;
    assign O_SRAM_WRITE_STROBE_N       = r_q.we_n;
    assign O_LCD_PIXEL_BUS             = r_q.pix;
    assign O_SEGMENT_SHIFT_CLOCK_GATED = r_q.sclk;
    assign O_LINE_LATCH_PULSE          = r_q.lp;
    assign O_FRAME_START_PULSE         = r_q.yd;
    assign O_FRAME_POLARITY            = r_q.fr;
    assign O_DISPLAY_BLANK_N           = r_q.dispn;
    assign O_ACTIVE_FRAME              = r_q.active;
    assign O_AUTO_MODE                 = r_q.auto_mode;
endmodule

// >>> lrc_top_asserts.sv
`timescale 1ns/1ps
// ----
// port checks
// ----
module lrc_top_asserts (
    input wire logic        I_MCLK,
    input wire logic        I_SRST,
    input wire logic        I_SLEEP_N,
    input wire logic [14:0] O_SRAM_ADDR,
    input wire logic [1:0]  O_SRAM_SELECT_N,
    input wire logic        O_SRAM_DATA_OE,
    input wire logic        O_SRAM_OUTPUT_ENABLE_N,
    input wire logic        O_SRAM_WRITE_STROBE_N,
    input wire logic [7:0]  O_LCD_PIXEL_BUS,
    input wire logic        O_SEGMENT_SHIFT_CLOCK_GATED,
    input wire logic        O_LINE_LATCH_PULSE,
    input wire logic        O_FRAME_START_PULSE,
    input wire logic        O_FRAME_POLARITY,
    input wire logic        O_DISPLAY_BLANK_N,
    input wire logic        O_ACTIVE_FRAME
);
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (I_SRST);
    // six low samples cover the sleep sync and the output register
    a_sleep_sram_idle: assert property (
        !I_SLEEP_N [*6] |-> O_SRAM_ADDR == 15'h0
            && O_SRAM_SELECT_N == 2'b11 && !O_SRAM_DATA_OE)
        else $error("sram pins active in sleep");
    a_sleep_lcd_low: assert property (
        !I_SLEEP_N [*6] |-> O_SRAM_OUTPUT_ENABLE_N && O_SRAM_WRITE_STROBE_N
            && {O_LCD_PIXEL_BUS, O_SEGMENT_SHIFT_CLOCK_GATED,
            O_LINE_LATCH_PULSE, O_FRAME_START_PULSE, O_FRAME_POLARITY,
            O_DISPLAY_BLANK_N} == 13'h0)
        else $error("lcd pins active in sleep");
    a_shift_in_active: assert property (
        O_SEGMENT_SHIFT_CLOCK_GATED |-> O_ACTIVE_FRAME
            && $stable(O_LCD_PIXEL_BUS))
        else $error("shift clock outside active frame");
    a_read_in_active: assert property (
        !O_SRAM_OUTPUT_ENABLE_N |-> O_ACTIVE_FRAME && O_SRAM_WRITE_STROBE_N
            ##1 O_SRAM_OUTPUT_ENABLE_N)
        else $error("refresh read outside its slot");
    a_write_slot: assert property (
        !O_SRAM_WRITE_STROBE_N |-> O_SRAM_DATA_OE
            ##1 (O_SRAM_WRITE_STROBE_N && !O_SRAM_DATA_OE))
        else $error("write strobe without one-cycle data drive");
    a_polarity_step: assert property (
        $rose(O_FRAME_START_PULSE) |-> $changed(O_FRAME_POLARITY))
        else $error("polarity did not toggle at frame start");
    a_shift_hold: assert property (
        $rose(O_LINE_LATCH_PULSE) |-> (O_SRAM_OUTPUT_ENABLE_N
            && !O_SEGMENT_SHIFT_CLOCK_GATED) [*7])
        else $error("line burst started too early");
    a_shift_start: assert property (
        $rose(O_LINE_LATCH_PULSE) ##1 O_ACTIVE_FRAME
            |-> ##[5:11] !O_SRAM_OUTPUT_ENABLE_N)
        else $error("line burst started too late");
endmodule

bind lrc_top lrc_top_asserts i_lrc_top_asserts (
    .I_MCLK, .I_SRST, .I_SLEEP_N, .O_SRAM_ADDR, .O_SRAM_SELECT_N,
    .O_SRAM_DATA_OE, .O_SRAM_OUTPUT_ENABLE_N, .O_SRAM_WRITE_STROBE_N,
    .O_LCD_PIXEL_BUS, .O_SEGMENT_SHIFT_CLOCK_GATED, .O_LINE_LATCH_PULSE,
    .O_FRAME_START_PULSE, .O_FRAME_POLARITY, .O_DISPLAY_BLANK_N,
    .O_ACTIVE_FRAME
);

// >>> lrc_top_tb.sv
`timescale 1ns/1ps
module lrc_top_tb;
    // ----
    // clocks, host pins, oscillator
    // ----
    logic        clk = 0, bclk = 0, srst = 1, cs_n = 1, dc = 1;
    logic        sleep_n = 1, osc = 0;
    logic [7:0]  dat = 8'h00, rd, wdat, pix;
    logic [7:0]  px [4];
    logic [14:0] addr;
    logic [1:0]  sel_n;
    logic        doe, oe_n, we_n, sclk, lp, yd, fr, blank_n, act, auto_m;
    logic [15:0] wa = 16'h1234;
    int          miscompares = 0, check_count = 0, nsc, i;
    always #10 clk = ~clk;
    always #15 bclk = ~bclk;
    // slow line rate so a full-width burst always fits in one line
    always #3000 osc = ~osc;

    lrc_top i_lrc_top (
        .I_MCLK(clk), .I_SRST(srst), .I_BUS_CLK(bclk), .I_CS_N(cs_n),
        .I_DATA(dat), .I_DATA_OR_COMMAND(dc), .I_SLEEP_N(sleep_n),
        .I_OSCILLATOR_INPUT(osc), .I_SRAM_DATA(rd), .O_SRAM_ADDR(addr),
        .O_SRAM_SELECT_N(sel_n), .O_SRAM_DATA(wdat), .O_SRAM_DATA_OE(doe),
        .O_SRAM_OUTPUT_ENABLE_N(oe_n), .O_SRAM_WRITE_STROBE_N(we_n),
        .O_LCD_PIXEL_BUS(pix), .O_SEGMENT_SHIFT_CLOCK_GATED(sclk),
        .O_LINE_LATCH_PULSE(lp), .O_FRAME_START_PULSE(yd),
        .O_FRAME_POLARITY(fr), .O_DISPLAY_BLANK_N(blank_n),
        .O_ACTIVE_FRAME(act), .O_AUTO_MODE(auto_m)
    );
    lrc_sram_model i_lrc_sram_model (
        .i_clk(clk), .i_addr(addr), .i_sel_n(sel_n), .i_data(wdat),
        .i_data_oe(doe), .i_oe_n(oe_n), .i_we_n(we_n), .o_data(rd)
    );

    task automatic check(input string nm, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic close_out;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // one host byte; select low and high long enough for the sync
    task automatic host(input logic c, input logic [7:0] b);
        @(negedge bclk);
        cs_n = 1'b0;
        dc = c;
        dat = b;
        repeat (4) @(negedge bclk);
        cs_n = 1'b1;
        repeat (4) @(negedge bclk);
    endtask

    // runs to the next frame start, counting shift pulses meanwhile
    task automatic wait_fs;
        logic p;
        p = yd;
        nsc = 0;
        for (int k = 0; k < 2000; k++) begin
            @(posedge clk);
            #1;
            if (sclk === 1'b1) begin
                px[nsc % 4] = pix;
                nsc++;
            end
            if (yd === 1'b1 && p === 1'b0) begin
                repeat (3) @(posedge clk);
                #1;
                return;
            end
            p = yd;
        end
        miscompares++;
        close_out();
    endtask

    task automatic chk_frame(input logic exp);
        logic f, a;
        f = fr;
        a = act;
        wait_fs();
        check("active", a, exp);
        check("shifts", nsc, exp ? 2 : 0);
        check("polarity", fr, {~f});
    endtask

    initial begin
        repeat (12) @(negedge clk);
        srst = 1'b0;
        repeat (2) @(negedge bclk);
        // one byte by two lines keeps every frame short
        host(1'b0, lrc_pkg::CMD_SIZE);
        host(1'b1, 8'h00);
        host(1'b1, 8'h01);
        host(1'b0, {lrc_pkg::CMD_ONOFF, 1'b1});
        host(1'b0, lrc_pkg::CMD_WADDR);
        host(1'b1, wa[7:0]);
        host(1'b1, wa[15:8]);
        host(1'b0, lrc_pkg::CMD_RADDR);
        host(1'b1, wa[7:0]);
        host(1'b1, wa[15:8]);
        host(1'b0, lrc_pkg::CMD_WRITE);
        for (i = 0; i < 3; i++) begin
            host(1'b1, 8'hA0 + 8'(i));
        end
        repeat (10) @(negedge clk);
        for (i = 0; i < 3; i++) begin
            check("sram", i_lrc_sram_model.mem[wa + i], 8'hA0 + i);
        end
        $display("write test done");
        wait_fs();
        host(1'b1, 8'h5A);
        wait_fs();
        chk_frame(1'b1);
        check("line 0 byte", px[0], 8'hA0);
        check("line 1 byte", px[1], 8'hA1);
        chk_frame(1'b0);
        check("sram", i_lrc_sram_model.mem[wa + 3], 8'h5A);
        $display("auto test done");
        host(1'b0, lrc_pkg::CMD_MANUAL);
        repeat (10) @(negedge clk);
        check("mode", auto_m, 1'b0);
        wait_fs();
        host(1'b0, lrc_pkg::CMD_XFER);
        wait_fs();
        chk_frame(1'b1);
        chk_frame(1'b0);
        chk_frame(1'b0);
        host(1'b0, lrc_pkg::CMD_XFER);
        wait_fs();
        chk_frame(1'b0);
        host(1'b0, lrc_pkg::CMD_AUTO);
        repeat (10) @(negedge clk);
        check("mode", auto_m, 1'b1);
        host(1'b0, lrc_pkg::CMD_XFER);
        wait_fs();
        chk_frame(1'b1);
        chk_frame(1'b0);
        $display("mode test done");
        check("blank", blank_n, 1'b1);
        // enter sleep after the line pulse so no burst is cut
        repeat (40) @(negedge clk);
        sleep_n = 1'b0;
        repeat (10) @(negedge clk);
        check("sram pins", {addr, sel_n, doe, oe_n, we_n}, 20'h0_001B);
        check("lcd pins", {pix, sclk, lp, yd, fr, blank_n}, 13'h0);
        host(1'b0, lrc_pkg::CMD_MANUAL);
        nsc = 0;
        for (i = 0; i < 700; i++) begin
            @(negedge clk);
            if (lp === 1'b1) begin
                nsc++;
            end
        end
        check("line pulses", nsc, 0);
        sleep_n = 1'b1;
        repeat (10) @(negedge clk);
        check("mode", auto_m, 1'b1);
        check("sram", i_lrc_sram_model.mem[wa], 8'hA0);
        wait_fs();
        $display("sleep test done");
        close_out();
    end
endmodule
